// ==== rtl/tlsm_pkg.sv ====
// Package of offsets, field positions and constants for the line status and mode registers
package tlsm_pkg;

   // Register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [7:0] OFS_LIVE = 8'h18;
   localparam logic [7:0] OFS_LEVEL = 8'h19;
   localparam logic [7:0] OFS_LATCH = 8'h1A;
   localparam logic [7:0] OFS_IE = 8'h1B;
   localparam logic [7:0] OFS_RX_MODE = 8'h20;
   localparam logic [7:0] OFS_TX_MODE = 8'h21;
   localparam logic [7:0] OFS_RX_CFG1 = 8'h22;

   // Reset value shared by every register
   localparam logic [7:0] RST_VAL = 8'h00;

   // Live and latched status fields
   localparam int BIT_OPEN = 2;
   localparam int BIT_SHORT = 1;
   localparam int BIT_LOSS = 0;
   localparam int CLR_OFS = 4;
   localparam int LEVEL_LSB = 4;
   localparam int LEVEL_W = 4;
   localparam int LIVE_W = 3;
   localparam logic [7:0] LATCH_MASK = 8'h77;

   // Master mode fields
   localparam int MM_EN = 7;
   localparam int MM_INIT = 6;
   localparam int MM_SRST = 1;
   localparam int MM_MODE = 0;
   localparam logic [7:0] MM_MASK = 8'hC3;

   // Receive configuration one fields
   localparam int CFG_SYNC_TIME = 7;
   localparam int CFG_SYNC_CRITERIA = 3;
   localparam int CFG_RESYNC = 0;

   // Qualified framing bit counts
   localparam int SYNC_CNT_W = 5;
   localparam logic [4:0] SYNC_BITS_SHORT = 5'h0A;
   localparam logic [4:0] SYNC_BITS_LONG = 5'h18;

   // Framer or formatter control states
   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_RUN = 2'b01,
      ST_OFF = 2'b11,
      ST_RST = 2'b10
   } tlsm_side_state_e;

endpackage : tlsm_pkg

// ==== rtl/tlsm_regs.sv ====
// Line status, interrupt and master mode register bank of the timing line transceiver
`timescale 1ns/1ps
`default_nettype none
module tlsm_regs (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Line detectors, asynchronous
   input wire logic line_open_det,
   input wire logic line_short_det,
   input wire logic line_loss_det,
   input wire logic [3:0] line_level,
   // Framing bit qualifier from the receive datapath
   input wire logic rx_frame_bit_ok,
   input wire logic rx_frame_bit_err,
   // Interrupt request
   output logic irq_out,
   // Receive framer control
   output logic rx_run,
   output logic rx_held_reset,
   output logic rx_low_power,
   output logic rx_e1_mode,
   output logic [7:0] rx_cfg,
   output logic rx_sync_criteria,
   output logic rx_in_sync,
   // Transmit formatter control
   output logic tx_run,
   output logic tx_held_reset,
   output logic tx_low_power,
   output logic tx_e1_mode
);
   // Synchronised detector values
   logic [tlsm_pkg::LIVE_W-1:0] live_raw, live_now;
   logic [tlsm_pkg::LEVEL_W-1:0] level_now;

   // Register state
   logic [tlsm_pkg::LIVE_W-1:0] live_prev_reg, live_prev_next;
   logic [7:0] latch_reg, latch_next;
   logic [7:0] ie_reg, ie_next;
   logic [7:0] rx_mode_reg, rx_mode_next;
   logic [7:0] tx_mode_reg, tx_mode_next;
   logic [7:0] rx_cfg_reg, rx_cfg_next;
   logic [7:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;

   // Framing bit qualifier state
   logic [tlsm_pkg::SYNC_CNT_W-1:0] sync_cnt_reg, sync_cnt_next;
   logic in_sync_reg, in_sync_next;
   logic resync_prev_reg, resync_prev_next;

   // Events and decoded writes
   logic [7:0] set_ev;
   logic [7:0] clr_w1;
   logic [tlsm_pkg::SYNC_CNT_W-1:0] sync_target;
   logic resync_req;

   tlsm_side_if rx_if ();
   tlsm_side_if tx_if ();

   // Detector pins cross into the core clock
   assign live_raw = {line_open_det, line_short_det, line_loss_det};

   tlsm_sync #(.W(tlsm_pkg::LIVE_W)) u_live_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(live_raw),
      .sync_out(live_now)
   );

   // Level is taken as a whole word so the field never shows a torn value
   tlsm_sync #(.W(tlsm_pkg::LEVEL_W)) u_level_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(line_level),
      .sync_out(level_now)
   );

   // Edge events per detector, one generate step each
   generate
      for (genvar i = 0; i < tlsm_pkg::LIVE_W; i++) begin : g_edge
         assign set_ev[i] = live_now[i] & ~live_prev_reg[i];
         assign set_ev[i + tlsm_pkg::CLR_OFS] = ~live_now[i] & live_prev_reg[i];
      end
   endgenerate
   assign set_ev[3] = 1'b0;
   assign set_ev[7] = 1'b0;

   assign clr_w1 = (reg_wr_en && reg_addr == tlsm_pkg::OFS_LATCH) ?
                   (reg_wdata & tlsm_pkg::LATCH_MASK) : tlsm_pkg::RST_VAL;

   // Latched flags, enables and interrupt; a new event beats a same-cycle clear
   always_comb begin
      live_prev_next = live_now;
      latch_next = (latch_reg & ~clr_w1) | set_ev;
      ie_next = ie_reg;
      if (reg_wr_en && reg_addr == tlsm_pkg::OFS_IE) begin
         ie_next = reg_wdata & tlsm_pkg::LATCH_MASK;
      end
      irq_next = |(latch_next & ie_next);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         live_prev_reg <= '0;
         latch_reg <= tlsm_pkg::RST_VAL;
         ie_reg <= tlsm_pkg::RST_VAL;
         irq_reg <= 1'b0;
      end else begin
         live_prev_reg <= live_prev_next;
         latch_reg <= latch_next;
         ie_reg <= ie_next;
         irq_reg <= irq_next;
      end
   end

   // Master mode and receive configuration writes
   always_comb begin
      rx_mode_next = rx_mode_reg;
      tx_mode_next = tx_mode_reg;
      rx_cfg_next = rx_cfg_reg;
      if (reg_wr_en) begin
         case (reg_addr)
            tlsm_pkg::OFS_RX_MODE: begin
               rx_mode_next = reg_wdata & tlsm_pkg::MM_MASK;
            end
            tlsm_pkg::OFS_TX_MODE: begin
               tx_mode_next = reg_wdata & tlsm_pkg::MM_MASK;
            end
            tlsm_pkg::OFS_RX_CFG1: begin
               rx_cfg_next = reg_wdata;
            end
            default: begin
               rx_cfg_next = rx_cfg_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rx_mode_reg <= tlsm_pkg::RST_VAL;
         tx_mode_reg <= tlsm_pkg::RST_VAL;
         rx_cfg_reg <= tlsm_pkg::RST_VAL;
      end else begin
         rx_mode_reg <= rx_mode_next;
         tx_mode_reg <= tx_mode_next;
         rx_cfg_reg <= rx_cfg_next;
      end
   end

   // Receive side mode bits to its control
   // receive enable
   assign rx_if.enable = rx_mode_reg[tlsm_pkg::MM_EN];
   assign rx_if.init_done = rx_mode_reg[tlsm_pkg::MM_INIT];
   assign rx_if.soft_reset = rx_mode_reg[tlsm_pkg::MM_SRST];
   assign rx_if.mode_sel = rx_mode_reg[tlsm_pkg::MM_MODE];

   // Transmit side mode bits, independent of receive
   // transmit enable
   assign tx_if.enable = tx_mode_reg[tlsm_pkg::MM_EN];
   assign tx_if.init_done = tx_mode_reg[tlsm_pkg::MM_INIT];
   assign tx_if.soft_reset = tx_mode_reg[tlsm_pkg::MM_SRST];
   assign tx_if.mode_sel = tx_mode_reg[tlsm_pkg::MM_MODE];

   tlsm_side_ctl u_rx_ctl (
      .clock(clock),
      .sys_rst(sys_rst),
      .side(rx_if.ctl)
   );

   tlsm_side_ctl u_tx_ctl (
      .clock(clock),
      .sys_rst(sys_rst),
      .side(tx_if.ctl)
   );

   assign sync_target = rx_cfg_reg[tlsm_pkg::CFG_SYNC_TIME] ?
                        tlsm_pkg::SYNC_BITS_LONG : tlsm_pkg::SYNC_BITS_SHORT;
   assign resync_req = rx_cfg_reg[tlsm_pkg::CFG_RESYNC] & ~resync_prev_reg;

   // Count consecutive qualified framing bits while running in T1
   always_comb begin
      sync_cnt_next = sync_cnt_reg;
      in_sync_next = in_sync_reg;
      resync_prev_next = rx_cfg_reg[tlsm_pkg::CFG_RESYNC];
      if (!rx_if.run || rx_if.e1_mode || resync_req) begin
         sync_cnt_next = '0;
         in_sync_next = 1'b0;
      end else if (!in_sync_reg) begin
         if (rx_frame_bit_err) begin
            sync_cnt_next = '0;
         end else if (rx_frame_bit_ok) begin
            if (sync_cnt_reg + 5'h01 >= sync_target) begin
               in_sync_next = 1'b1;
               sync_cnt_next = '0;
            end else begin
               sync_cnt_next = sync_cnt_reg + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync_cnt_reg <= '0;
         in_sync_reg <= 1'b0;
         resync_prev_reg <= 1'b0;
      end else begin
         sync_cnt_reg <= sync_cnt_next;
         in_sync_reg <= in_sync_next;
         resync_prev_reg <= resync_prev_next;
      end
   end

   // Read mux, registered; unmapped offsets read zero
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd_en) begin
         case (reg_addr)
            tlsm_pkg::OFS_LIVE: begin
               rdata_next = {5'h00, live_now};
            end
            tlsm_pkg::OFS_LEVEL: begin
               rdata_next = {level_now, 4'h0};
            end
            tlsm_pkg::OFS_LATCH: begin
               rdata_next = latch_reg;
            end
            tlsm_pkg::OFS_IE: begin
               rdata_next = ie_reg;
            end
            tlsm_pkg::OFS_RX_MODE: begin
               rdata_next = rx_mode_reg;
            end
            tlsm_pkg::OFS_TX_MODE: begin
               rdata_next = tx_mode_reg;
            end
            tlsm_pkg::OFS_RX_CFG1: begin
               rdata_next = rx_cfg_reg;
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Outputs
   assign reg_rdata = rdata_reg;
   assign irq_out = irq_reg;
   assign rx_run = rx_if.run;
   assign rx_held_reset = rx_if.held_reset;
   assign rx_low_power = rx_if.low_power;
   assign rx_e1_mode = rx_if.e1_mode;
   assign rx_cfg = rx_cfg_reg;
   assign rx_sync_criteria = rx_cfg_reg[tlsm_pkg::CFG_SYNC_CRITERIA];
   assign rx_in_sync = in_sync_reg;
   assign tx_run = tx_if.run;
   assign tx_held_reset = tx_if.held_reset;
   assign tx_low_power = tx_if.low_power;
   assign tx_e1_mode = tx_if.e1_mode;
endmodule : tlsm_regs
`default_nettype wire

// ==== rtl/tlsm_side_ctl.sv ====
// Enable, soft reset and initialisation sequencing for one framer or formatter
`timescale 1ns/1ps
`default_nettype none
module tlsm_side_ctl (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Mode bits in, state out
   tlsm_side_if.ctl side
);
   tlsm_pkg::tlsm_side_state_e state_reg, state_next;
   logic mode_reg, mode_next;

   // Soft reset wins, then the init gate, then the enable choice
   always_comb begin
      mode_next = side.mode_sel;
      if (side.soft_reset) begin
         state_next = tlsm_pkg::ST_RST;
      end else if (!side.init_done) begin
         state_next = tlsm_pkg::ST_WAIT;
      end else if (side.enable) begin
         state_next = tlsm_pkg::ST_RUN;
      end else begin
         state_next = tlsm_pkg::ST_OFF;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= tlsm_pkg::ST_WAIT;
         mode_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
      end
   end

   // Decode state; waiting before init counts as low power too
   always_comb begin
      side.run = 1'b0;
      side.held_reset = 1'b0;
      side.low_power = 1'b0;
      case (state_reg)
         tlsm_pkg::ST_RUN: begin
            side.run = 1'b1;
         end
         tlsm_pkg::ST_RST: begin
            side.held_reset = 1'b1;
         end
         tlsm_pkg::ST_OFF, tlsm_pkg::ST_WAIT: begin
            side.low_power = 1'b1;
         end
         default: begin
            side.low_power = 1'b1;
         end
      endcase
   end

   // Zero selects T1, one selects E1
   assign side.e1_mode = mode_reg;
endmodule : tlsm_side_ctl
`default_nettype wire

// ==== rtl/tlsm_side_if.sv ====
// Interface joining the register bank to one framer or formatter control
`timescale 1ns/1ps
`default_nettype none
interface tlsm_side_if;
   logic enable;
   logic init_done;
   logic soft_reset;
   logic mode_sel;
   logic run;
   logic held_reset;
   logic low_power;
   logic e1_mode;

   // Register bank drives the mode bits
   modport regs (output enable, output init_done, output soft_reset, output mode_sel,
                 input run, input held_reset, input low_power, input e1_mode);
   // Control reads them and reports its state
   modport ctl (input enable, input init_done, input soft_reset, input mode_sel,
                output run, output held_reset, output low_power, output e1_mode);
endinterface : tlsm_side_if
`default_nettype wire

// ==== rtl/tlsm_sync.sv ====
// Three-stage synchroniser that passes a vector once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module tlsm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Asynchronous input and settled output
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
   logic [W-1:0] out_next;

   // Stage one feeds only stage two; output moves only on agreement
   always_comb begin
      out_next = out_reg;
      if (s2_reg == s3_reg) begin
         out_next = s3_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         out_reg <= '0;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign sync_out = out_reg;
endmodule : tlsm_sync
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the line status and mode register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   // Stimulus and observed ports
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [2:0] det = 3'h0;
   logic [3:0] line_level = 4'h0;
   logic ok_bit = 1'b0;
   logic err_bit = 1'b0;
   logic [7:0] reg_rdata, rx_cfg;
   logic irq_out, rx_run, rx_held_reset, rx_low_power, rx_e1_mode, rx_sync_criteria;
   logic rx_in_sync, tx_run, tx_held_reset, tx_low_power, tx_e1_mode;
   int err_count = 0;
   int tests_run = 0;

   tlsm_regs u_dut (.clock, .sys_rst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
      .reg_rdata, .line_open_det(det[2]), .line_short_det(det[1]), .line_loss_det(det[0]),
      .line_level, .rx_frame_bit_ok(ok_bit), .rx_frame_bit_err(err_bit), .irq_out, .rx_run,
      .rx_held_reset, .rx_low_power, .rx_e1_mode, .rx_cfg, .rx_sync_criteria, .rx_in_sync,
      .tx_run, .tx_held_reset, .tx_low_power, .tx_e1_mode);

   // 100 MHz core clock
   initial begin
      forever #5 clock = ~clock;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick

   // One-cycle strobes, then a quiet edge so back-to-back calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      tick(1);
      reg_wr_en = 1'b0;
      tick(1);
   endtask : wr

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd_en = 1'b1;
      tick(1);
      reg_rd_en = 1'b0;
      tick(1);
      chk($sformatf("register %h", a), e, reg_rdata);
   endtask : rc

   task automatic irq_is(input logic e);
      chk("irq_out", {7'h00, e}, {7'h00, irq_out});
   endtask : irq_is

   // Every register starts at zero, both sides powered down
   task automatic t_reset();
      logic [7:0] ofs [7];
      ofs = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h20, 8'h21, 8'h22};
      foreach (ofs[i]) rc(ofs[i], tlsm_pkg::RST_VAL);
      chk("low power", 8'h03, {6'h00, rx_low_power, tx_low_power});
   endtask : t_reset

   // Read-only, unmapped and masked writes
   task automatic t_access();
      wr(8'h18, 8'hFF);
      wr(8'h19, 8'hFF);
      wr(8'h30, 8'hFF);
      rc(8'h18, 8'h00);
      rc(8'h19, 8'h00);
      rc(8'h30, 8'h00);
      wr(8'h1B, 8'hFF);
      rc(8'h1B, 8'h77);
      wr(8'h1B, 8'h00);
      wr(8'h22, 8'hA5);
      rc(8'h22, 8'hA5);
      chk("rx_cfg", 8'hA5, rx_cfg);
      wr(8'h22, 8'h08);
      tick(2);
      chk("rx_sync_criteria", 8'h01, {7'h00, rx_sync_criteria});
      wr(8'h22, 8'h00);
   endtask : t_access

   // Each detector: rise, no-op write, clear, fall, clear; long wait covers the synchroniser
   task automatic t_line();
      for (int b = 0; b < 3; b++) begin
         det[b] = 1'b1;
         tick(8);
         rc(8'h18, 8'h01 << b);
         rc(8'h1A, 8'h01 << b);
         wr(8'h1A, 8'h00);
         rc(8'h1A, 8'h01 << b);
         wr(8'h1A, 8'h01 << b);
         rc(8'h1A, 8'h00);
         det[b] = 1'b0;
         tick(8);
         rc(8'h18, 8'h00);
         rc(8'h1A, 8'h10 << b);
         wr(8'h1A, 8'h10 << b);
         rc(8'h1A, 8'h00);
      end
   endtask : t_line

   // All sixteen level codes
   task automatic t_level();
      for (int v = 0; v < 16; v++) begin
         line_level = v[3:0];
         tick(8);
         rc(8'h19, {v[3:0], 4'h0});
      end
      line_level = 4'h0;
   endtask : t_level

   // Raise, mask, unmask, then clear two pending flags one at a time
   task automatic t_irq();
      wr(8'h1B, 8'h01);
      det[0] = 1'b1;
      tick(8);
      irq_is(1'b1);
      wr(8'h1B, 8'h00);
      irq_is(1'b0);
      wr(8'h1B, 8'h11);
      irq_is(1'b1);
      det[0] = 1'b0;
      tick(8);
      wr(8'h1A, 8'h01);
      irq_is(1'b1);
      wr(8'h1A, 8'h10);
      irq_is(1'b0);
      wr(8'h1B, 8'h00);
   endtask : t_irq

   // Mode sequence on one side; the other side must not follow
   task automatic t_mode(input logic [7:0] ofs);
      logic [7:0] w [7];
      logic [2:0] e [7];
      logic [3:0] s;
      // enable and mode written before init done
      w = '{8'h80, 8'h81, 8'hC1, 8'hFF, 8'hC1, 8'hC0, 8'h40};
      e = '{3'b000, 3'b001, 3'b101, 3'b011, 3'b101, 3'b100, 3'b000};
      foreach (w[i]) begin
         wr(ofs, w[i]);
         s = ofs[0] ? {tx_run, tx_held_reset, tx_e1_mode, tx_low_power}
                    : {rx_run, rx_held_reset, rx_e1_mode, rx_low_power};
         chk("side state", {5'h00, e[i]}, {5'h00, s[3:1]});
         if (!e[i][1]) chk("low power", {7'h00, !e[i][2]}, {7'h00, s[0]});
         chk("other side e1", 8'h00, {7'h00, ofs[0] ? rx_e1_mode : tx_e1_mode});
         if (w[i] == 8'hFF) rc(ofs, 8'hC3);
      end
      wr(ofs, 8'h00);
   endtask : t_mode

   // Qualified framing bits until sync, then E1 drops it
   task automatic t_sync(input logic [7:0] cfg, input int n);
      wr(8'h20, 8'h00);
      wr(8'h22, cfg);
      wr(8'h20, 8'h80);
      wr(8'h20, 8'hC0);
      for (int i = 0; i < n; i++) begin
         ok_bit = 1'b1;
         tick(1);
         ok_bit = 1'b0;
         tick(1);
         chk("rx_in_sync", {7'h00, i == n - 1}, {7'h00, rx_in_sync});
      end
      wr(8'h20, 8'hC1);
      tick(1);
      chk("rx_in_sync e1", 8'h00, {7'h00, rx_in_sync});
      wr(8'h20, 8'h00);
   endtask : t_sync

   // An errored framing bit restarts the count; a rising resync bit drops sync
   task automatic t_qualify();
      wr(8'h20, 8'h00);
      wr(8'h22, 8'h00);
      wr(8'h20, 8'h80);
      wr(8'h20, 8'hC0);
      for (int i = 0; i < 15; i++) begin
         ok_bit = (i != 4);
         err_bit = (i == 4);
         tick(1);
         ok_bit = 1'b0;
         err_bit = 1'b0;
         tick(1);
         chk("rx_in_sync err", {7'h00, i == 14}, {7'h00, rx_in_sync});
      end
      wr(8'h22, 8'h01);
      chk("rx_in_sync resync", 8'h00, {7'h00, rx_in_sync});
      wr(8'h20, 8'h00);
   endtask : t_qualify

   // Reset in mid-run returns registers, flags and both sides to idle
   task automatic t_rerun();
      wr(8'h1B, 8'h77);
      wr(8'h21, 8'h81);
      wr(8'h21, 8'hC1);
      det[1] = 1'b1;
      tick(8);
      irq_is(1'b1);
      chk("tx_run", 8'h01, {7'h00, tx_run});
      sys_rst = 1'b1;
      det[1] = 1'b0;
      tick(4);
      sys_rst = 1'b0;
      irq_is(1'b0);
      t_reset();
      tick(8);
      rc(8'h1A, 8'h00);
   endtask : t_rerun

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence after four reset cycles
   initial begin
      repeat (4) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      t_reset();
      t_access();
      t_line();
      t_level();
      t_irq();
      t_mode(8'h20);
      t_mode(8'h21);
      t_qualify();
      t_sync(8'h00, 10);
      t_sync(8'h80, 24);
      t_rerun();
      tally_and_finish();
   end

   // Watchdog well beyond the roughly 560 cycles the run needs
   initial begin
      repeat (8000) @(posedge clock);
      err_count++;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire

// ==== sim/tlsm_regs_monitor.sv ====
// Concurrent checks on the ports of the line status and mode register bank
`timescale 1ns/1ps
`default_nettype none
module tlsm_regs_mon (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Interrupt and side state
   input wire logic irq_out,
   input wire logic rx_run,
   input wire logic rx_held_reset,
   input wire logic rx_low_power,
   input wire logic rx_e1_mode,
   input wire logic rx_in_sync,
   input wire logic tx_run,
   input wire logic tx_held_reset,
   input wire logic tx_low_power,
   input wire logic tx_e1_mode
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // Mode write with a quiet cycle after it shows two edges later
   property p_mode(ofs, run, held, e1);
      reg_wr_en && reg_addr == ofs ##1 !reg_wr_en |=>
         held == $past(reg_wdata[1], 2) && e1 == $past(reg_wdata[0], 2) &&
         run == (&$past(reg_wdata[7:6], 2) && !$past(reg_wdata[1], 2));
   endproperty

   a_live_upper_zero: assert property (reg_rd_en && reg_addr == 8'h18 |=> reg_rdata[7:3] == 5'h00)
      else $error("live status upper bits not zero");
   a_level_low_zero: assert property (reg_rd_en && reg_addr == 8'h19 |=> reg_rdata[3:0] == 4'h0)
      else $error("level register low bits not zero");
   a_latch_gaps: assert property (reg_rd_en && reg_addr == 8'h1A |=> (reg_rdata & 8'h88) == 8'h00)
      else $error("latched status reserved bits set");
   a_unmapped_zero: assert property (reg_rd_en && reg_addr == 8'h30 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_irq_masked: assert property (reg_wr_en && reg_addr == 8'h1B && reg_wdata == 8'h00 ##1 !reg_wr_en |=> !irq_out)
      else $error("interrupt stays with all enables off");
   a_rx_mode_follow: assert property (p_mode(8'h20, rx_run, rx_held_reset, rx_e1_mode))
      else $error("receive side state wrong after mode write");
   a_tx_mode_follow: assert property (p_mode(8'h21, tx_run, tx_held_reset, tx_e1_mode))
      else $error("transmit side state wrong after mode write");
   a_rx_power_state: assert property (!rx_held_reset |-> rx_low_power == !rx_run)
      else $error("receive low power disagrees with run");
   a_tx_power_state: assert property (!tx_held_reset |-> tx_low_power == !tx_run)
      else $error("transmit low power disagrees with run");
   a_sync_needs_run: assert property (!rx_run |=> !rx_in_sync)
      else $error("in sync while framer not running");

   // Main scenarios reached
   c_irq: cover property (irq_out);
   c_in_sync: cover property (rx_in_sync);
   c_tx_held: cover property (tx_held_reset);
endmodule : tlsm_regs_mon

bind tlsm_regs tlsm_regs_mon u_mon (.clock, .sys_rst, .reg_addr, .reg_wr_en, .reg_rd_en,
   .reg_wdata, .reg_rdata, .irq_out, .rx_run, .rx_held_reset, .rx_low_power, .rx_e1_mode,
   .rx_in_sync, .tx_run, .tx_held_reset, .tx_low_power, .tx_e1_mode);
`default_nettype wire
